// ==== core/audio_link_regs.svh ====
// Purpose: offsets, field positions, reset values of the audio/link regs
// Assumes: 8-bit register port, byte offsets as printed
// Notes: included by the bank only; the checker and bench use literal values
`ifndef AUDIO_LINK_REGS_SVH
`define AUDIO_LINK_REGS_SVH
`define AUDIO_CFG_ADDR 8'h55
`define LINK_STATUS_ADDR 8'h5A
`define AUDIO_SOURCE_ADDR 8'h60
`define INT_STATUS_ADDR 8'h61
`define INT_CLEAR_ADDR 8'h62
`define INT_ENABLE_ADDR 8'h63
`define AUDIO_CFG_RESET 8'h0C
`define AUDIO_CFG_WMASK 8'hCF
`define AUDIO_SOURCE_RESET 2'h0
`define INT_RESET 6'h00
`define CFG_TDM_EN_BIT 7
`define CFG_PIN_OUT_BIT 6
`define CFG_RST_TYPE_BIT 3
`define CFG_RST_AIF_BIT 2
`define CFG_RST_AVI_BIT 1
`define CFG_RST_ACR_BIT 0
`define SRC_HDMI 2'h0
`define SRC_LOCAL 2'h1
`define INT_FIFO_RESET_BIT 0
`define INT_LINK_READY_BIT 1
`define INT_TX_LOST_BIT 2
`define INT_TMDS_LOST_BIT 3
`define INT_PLL_LOST_BIT 4
`define INT_NO_CLK_BIT 5
`define INT_W 6
`endif

// ==== core/audio_link_pkg.sv ====
// Purpose: types shared by the audio config and link status bank
// Assumes: nothing beyond the header
// Notes: all uses are scoped, nothing imported
package audio_link_pkg;
  typedef struct packed {
    logic sck;
    logic ws;
    logic [3:0] sd;
  } i2s_t;

  typedef struct packed {
    logic [3:0] audio_type;
    logic [7:0] aif_sum;
    logic [7:0] avi_sum;
    logic [19:0] acr_n;
    logic [19:0] acr_cts;
  } pkt_info_t;

  typedef struct packed {
    logic link_ready;
    logic tx_active;
    logic remote_lock;
    logic input_valid;
    logic mode_entered;
    logic [1:0] port_mode;
    logic tmds_data_recovered;
    logic pll_lock;
    logic no_clk;
    logic input_frequency_settled;
  } status_in_t;
endpackage

// ==== core/audio_cfg_link_status_regs.sv ====
// Purpose: audio configuration and link/input status register bank
// Assumes: status sources and local i2s pins are asynchronous
// Notes: hdmi packet info and tdm audio come from ref_clk logic
`timescale 1ns/10ps
`default_nettype none
`include "audio_link_regs.svh"
module audio_cfg_link_status_regs
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire audio_link_pkg::status_in_t status_in,
  input wire audio_link_pkg::pkt_info_t pkt_info,
  input wire audio_link_pkg::i2s_t hdmi_i2s,
  input wire audio_link_pkg::i2s_t tdm_i2s,
  input wire audio_link_pkg::i2s_t i2s_pin_in,
  output audio_link_pkg::i2s_t i2s_pin_out,
  output logic [5:0] i2s_pin_oe,
  output logic tdm_conv_en,
  output logic link_clk_from_tdm,
  output audio_link_pkg::i2s_t link_audio,
  output logic fifo_reset,
  output logic irq
);

  localparam int STS_W = $bits(audio_link_pkg::status_in_t);
  localparam int PIN_W = $bits(audio_link_pkg::i2s_t);
  localparam int SYNC_W = STS_W + PIN_W;

  // software state
  logic [7:0] audio_cfg_ff;
  logic [1:0] audio_source_ff;
  logic [`INT_W-1:0] int_status_ff;
  logic [`INT_W-1:0] int_enable_ff;
  logic [7:0] rdata_ff;

  // synchronised inputs
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] sync3_ff;
  logic [SYNC_W-1:0] clean_ff;
  audio_link_pkg::status_in_t sts;
  audio_link_pkg::status_in_t sts_prev_ff;
  audio_link_pkg::i2s_t local_i2s;

  // packet change tracking
  audio_link_pkg::pkt_info_t pkt_prev_ff;
  logic pkt_seen_ff;
  logic fifo_reset_ff;

  // audio path
  audio_link_pkg::i2s_t link_audio_ff;
  audio_link_pkg::i2s_t pin_out_ff;
  logic pin_drive_ff;
  logic tdm_en_ff;

  // decode
  wire sel_cfg = reg_addr == `AUDIO_CFG_ADDR;
  wire sel_sts = reg_addr == `LINK_STATUS_ADDR;
  wire sel_src = reg_addr == `AUDIO_SOURCE_ADDR;
  wire sel_ists = reg_addr == `INT_STATUS_ADDR;
  wire sel_iclr = reg_addr == `INT_CLEAR_ADDR;
  wire sel_ien = reg_addr == `INT_ENABLE_ADDR;
  wire wr_cfg = reg_wr && sel_cfg;
  wire wr_src = reg_wr && sel_src;
  wire wr_iclr = reg_wr && sel_iclr;
  wire wr_ien = reg_wr && sel_ien;

  // configuration fields
  wire cfg_tdm_en = audio_cfg_ff[`CFG_TDM_EN_BIT];
  wire cfg_pin_out = audio_cfg_ff[`CFG_PIN_OUT_BIT];
  wire cfg_rst_type = audio_cfg_ff[`CFG_RST_TYPE_BIT];
  wire cfg_rst_aif = audio_cfg_ff[`CFG_RST_AIF_BIT];
  wire cfg_rst_avi = audio_cfg_ff[`CFG_RST_AVI_BIT];
  wire cfg_rst_acr = audio_cfg_ff[`CFG_RST_ACR_BIT];
  wire src_hdmi = audio_source_ff == `SRC_HDMI;
  wire src_local = audio_source_ff == `SRC_LOCAL;

  // the software write side is a plain byte; reserved bits never stick
  wire [7:0] nxt_audio_cfg = wr_cfg ?
    (reg_wdata & `AUDIO_CFG_WMASK) : audio_cfg_ff;
  wire [1:0] nxt_audio_source = wr_src ?
    reg_wdata[1:0] : audio_source_ff;
  wire [`INT_W-1:0] nxt_int_enable = wr_ien ?
    reg_wdata[`INT_W-1:0] : int_enable_ff;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      audio_cfg_ff <= `AUDIO_CFG_RESET;
      audio_source_ff <= `AUDIO_SOURCE_RESET;
      int_enable_ff <= `INT_RESET;
    end
    else
    begin
      audio_cfg_ff <= nxt_audio_cfg;
      audio_source_ff <= nxt_audio_source;
      int_enable_ff <= nxt_int_enable;
    end
  end

  // three-stage synchroniser, value moves once stages two and three agree
  assign sync_in = {status_in, i2s_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
          clean_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= sync_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi])
          begin
            clean_ff[gi] <= sync3_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign sts = clean_ff[SYNC_W-1:PIN_W];
  assign local_i2s = clean_ff[PIN_W-1:0];

  // status composition
  wire st_link_ready = sts.link_ready;
  // lock alone is not enough: input and mode must be settled too
  wire st_tx_locked = sts.tx_active && sts.remote_lock
    && sts.input_valid && sts.mode_entered;
  // the mode field is meaningless while unlocked, so it reads 00
  wire [1:0] st_port_mode = st_tx_locked ?
    sts.port_mode : 2'h0;
  wire st_tmds = sts.tmds_data_recovered;
  wire st_pll = sts.pll_lock;
  wire st_no_clk = sts.no_clk;
  wire st_freq = sts.input_frequency_settled;

  wire [7:0] status_word = {
    st_link_ready,
    st_tx_locked,
    st_port_mode,
    st_tmds,
    st_pll,
    st_no_clk,
    st_freq
  };

  logic tx_locked_prev_ff;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sts_prev_ff <= '0;
      tx_locked_prev_ff <= 1'b0;
    end
    else
    begin
      sts_prev_ff <= sts;
      tx_locked_prev_ff <= st_tx_locked;
    end
  end

  // fifo reset on packet content change
  wire type_chg = pkt_info.audio_type != pkt_prev_ff.audio_type;
  wire aif_chg = pkt_info.aif_sum != pkt_prev_ff.aif_sum;
  wire avi_chg = pkt_info.avi_sum != pkt_prev_ff.avi_sum;
  wire acr_chg = (pkt_info.acr_n != pkt_prev_ff.acr_n)
    || (pkt_info.acr_cts != pkt_prev_ff.acr_cts);

  // the first sample after reset only primes the history
  wire rst_by_type = cfg_rst_type && type_chg;
  wire rst_by_aif = cfg_rst_aif && aif_chg;
  wire rst_by_avi = cfg_rst_avi && avi_chg;
  wire rst_by_acr = cfg_rst_acr && acr_chg;
  wire nxt_fifo_reset = pkt_seen_ff &&
    (rst_by_type || rst_by_aif || rst_by_avi || rst_by_acr);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pkt_prev_ff <= '0;
      pkt_seen_ff <= 1'b0;
      fifo_reset_ff <= 1'b0;
    end
    else
    begin
      pkt_prev_ff <= pkt_info;
      pkt_seen_ff <= 1'b1;
      fifo_reset_ff <= nxt_fifo_reset;
    end
  end

  // audio routing
  audio_link_pkg::i2s_t nxt_link_audio;

  // conversion clock wins over any source choice while enabled
  assign nxt_link_audio = tdm_en_ff ? tdm_i2s :
    (src_local ? local_i2s : hdmi_i2s);

  wire nxt_pin_drive = cfg_pin_out && src_hdmi;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tdm_en_ff <= 1'b0;
      link_audio_ff <= '0;
      pin_out_ff <= '0;
      pin_drive_ff <= 1'b0;
    end
    else
    begin
      tdm_en_ff <= cfg_tdm_en;
      link_audio_ff <= nxt_link_audio;
      pin_out_ff <= nxt_pin_drive ? hdmi_i2s : '0;
      pin_drive_ff <= nxt_pin_drive;
    end
  end

  // interrupt events
  wire [`INT_W-1:0] int_event;

  assign int_event[`INT_FIFO_RESET_BIT] = fifo_reset_ff;
  assign int_event[`INT_LINK_READY_BIT] =
    sts.link_ready && !sts_prev_ff.link_ready;
  assign int_event[`INT_TX_LOST_BIT] =
    tx_locked_prev_ff && !st_tx_locked;
  assign int_event[`INT_TMDS_LOST_BIT] =
    sts_prev_ff.tmds_data_recovered && !sts.tmds_data_recovered;
  assign int_event[`INT_PLL_LOST_BIT] =
    sts_prev_ff.pll_lock && !sts.pll_lock;
  assign int_event[`INT_NO_CLK_BIT] =
    sts.no_clk && !sts_prev_ff.no_clk;

  // a new event in the clearing cycle must survive, so set wins
  wire [`INT_W-1:0] int_clr_mask = wr_iclr ?
    reg_wdata[`INT_W-1:0] : `INT_RESET;
  wire [`INT_W-1:0] nxt_int_status =
    (int_status_ff & ~int_clr_mask) | int_event;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_status_ff <= `INT_RESET;
    end
    else
    begin
      int_status_ff <= nxt_int_status;
    end
  end

  // read side: one cycle latency, unmapped and write-only read zero
  wire [7:0] rd_cfg = sel_cfg ? audio_cfg_ff : 8'h00;
  wire [7:0] rd_sts = sel_sts ? status_word : 8'h00;
  wire [7:0] rd_src = sel_src ? {6'h00, audio_source_ff} : 8'h00;
  wire [7:0] rd_ists = sel_ists ? {2'h0, int_status_ff} : 8'h00;
  wire [7:0] rd_ien = sel_ien ? {2'h0, int_enable_ff} : 8'h00;
  wire [7:0] nxt_rdata = reg_rd ?
    (rd_cfg | rd_sts | rd_src | rd_ists | rd_ien) : 8'h00;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs
  assign reg_rdata = rdata_ff;
  assign tdm_conv_en = tdm_en_ff;
  assign link_clk_from_tdm = tdm_en_ff;
  assign link_audio = link_audio_ff;
  assign i2s_pin_out = pin_out_ff;
  // all six lines turn together; partial drive would fight the source
  assign i2s_pin_oe = {PIN_W{pin_drive_ff}};
  assign fifo_reset = fifo_reset_ff;
  assign irq = |(int_status_ff & int_enable_ff);

endmodule
`default_nettype wire

// ==== testbench/audio_cfg_link_status_regs_sva.sv ====
// Purpose: port checker for the audio config and link status bank
// Assumes: shadow copies of cfg and source follow the register port
// Notes: pin enable checks allow two cycles of settling before they bite
`timescale 1ns/10ps
`default_nettype none
module audio_cfg_link_status_regs_chk
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire audio_link_pkg::pkt_info_t pkt_info,
  input wire audio_link_pkg::i2s_t hdmi_i2s,
  input wire audio_link_pkg::i2s_t i2s_pin_out,
  input wire logic [5:0] i2s_pin_oe,
  input wire logic tdm_conv_en,
  input wire logic link_clk_from_tdm,
  input wire logic fifo_reset
);
  logic [7:0] cfg_ff;
  logic [1:0] src_ff;
  wire pins_on = cfg_ff[6] && src_ff == 2'h0;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      cfg_ff <= 8'h0C;
      src_ff <= 2'h0;
    end
    else if (reg_wr && reg_addr == 8'h55)
      cfg_ff <= reg_wdata & 8'hCF;
    else if (reg_wr && reg_addr == 8'h60)
      src_ff <= reg_wdata[1:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_tdm;
    tdm_conv_en == $past(cfg_ff[7]);
  endproperty
  a_tdm: assert property (p_tdm) else $error("tdm enable");
  property p_clk;
    link_clk_from_tdm == $past(cfg_ff[7]);
  endproperty
  a_clk: assert property (p_clk) else $error("link clock");
  property p_pin_on;
    pins_on [*3] |-> i2s_pin_oe == 6'h3F;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pins off");
  // source select other than hdmi must keep the pins released
  property p_pin_off;
    !pins_on [*3] |-> i2s_pin_oe == 6'h00;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pins on");
  property p_pin_data;
    i2s_pin_oe[0] |-> i2s_pin_out == $past(hdmi_i2s);
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pin data");
  property p_type;
    cfg_ff[3] && pkt_info.audio_type != $past(pkt_info.audio_type)
      |=> fifo_reset;
  endproperty
  a_type: assert property (p_type) else $error("type reset");
  property p_aif;
    cfg_ff[2] && pkt_info.aif_sum != $past(pkt_info.aif_sum) |=> fifo_reset;
  endproperty
  a_aif: assert property (p_aif) else $error("aif reset");
  property p_avi;
    cfg_ff[1] && pkt_info.avi_sum != $past(pkt_info.avi_sum) |=> fifo_reset;
  endproperty
  a_avi: assert property (p_avi) else $error("avi reset");
  property p_acr;
    cfg_ff[0] && {pkt_info.acr_n, pkt_info.acr_cts} !=
      $past({pkt_info.acr_n, pkt_info.acr_cts}) |=> fifo_reset;
  endproperty
  a_acr: assert property (p_acr) else $error("acr reset");
  property p_quiet;
    pkt_info == $past(pkt_info) |=> !fifo_reset;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray reset");
endmodule
bind audio_cfg_link_status_regs audio_cfg_link_status_regs_chk i_chk
(
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pkt_info(pkt_info),
  .hdmi_i2s(hdmi_i2s), .i2s_pin_out(i2s_pin_out), .i2s_pin_oe(i2s_pin_oe),
  .tdm_conv_en(tdm_conv_en), .link_clk_from_tdm(link_clk_from_tdm),
  .fifo_reset(fifo_reset)
);
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the audio config and status bank
// Assumes: no bus waits, read data one cycle after the strobe
// Notes: status inputs get 6 cycles to pass the synchronisers
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  audio_link_pkg::status_in_t status_in = 11'h000;
  audio_link_pkg::pkt_info_t pkt_info = 60'h0;
  audio_link_pkg::i2s_t hdmi_i2s = 6'h2D;
  audio_link_pkg::i2s_t tdm_i2s = 6'h1A;
  audio_link_pkg::i2s_t pin_in = 6'h33;
  audio_link_pkg::i2s_t i2s_pin_out, link_audio;
  logic [5:0] i2s_pin_oe;
  logic tdm_conv_en, link_clk_from_tdm, fifo_reset, irq, seen;
  int err_count = 0;
  int n_compared = 0;
  logic [10:0] st [9] = '{11'h400, 11'h3E0, 11'h3B0, 11'h008, 11'h004,
    11'h002, 11'h001, 11'h7D0, 11'h3C0};
  logic [7:0] sx [9] = '{8'h80, 8'h60, 8'h00, 8'h08, 8'h04, 8'h02, 8'h01,
    8'hD0, 8'h40};
  always #2 ref_clk = ~ref_clk;
  audio_cfg_link_status_regs i_audio_cfg_link_status_regs
  (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .status_in(status_in), .pkt_info(pkt_info),
    .hdmi_i2s(hdmi_i2s), .tdm_i2s(tdm_i2s), .i2s_pin_in(pin_in),
    .i2s_pin_out(i2s_pin_out), .i2s_pin_oe(i2s_pin_oe),
    .tdm_conv_en(tdm_conv_en), .link_clk_from_tdm(link_clk_from_tdm),
    .link_audio(link_audio), .fifo_reset(fifo_reset), .irq(irq)
  );
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stands one cycle only, so it is sampled right after that edge
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    chk("reg_rdata", e, reg_rdata & m);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    end_sim;
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(8'h55, 8'hFF, 8'h0C);
    rd(8'h5A, 8'hFF, 8'h00);
    rd(8'h40, 8'hFF, 8'h00);
    $display("test reset done");
    wr(8'h55, 8'hFF);
    wr(8'h5A, 8'hFF);
    rd(8'h55, 8'hFF, 8'hCF);
    chk("tdm_conv_en", 8'h01, {7'h00, tdm_conv_en});
    chk("link_clk", 8'h01, {7'h00, link_clk_from_tdm});
    chk("link_audio", 8'h1A, {2'h0, link_audio});
    chk("i2s_pin_oe", 8'h3F, {2'h0, i2s_pin_oe});
    chk("i2s_pin_out", 8'h2D, {2'h0, i2s_pin_out});
    wr(8'h60, 8'h01);
    wr(8'h55, 8'h40);
    cyc(6);
    chk("i2s_pin_oe", 8'h00, {2'h0, i2s_pin_oe});
    chk("link_audio", 8'h33, {2'h0, link_audio});
    rd(8'h60, 8'h03, 8'h01);
    wr(8'h60, 8'h00);
    cyc(3);
    chk("i2s_pin_oe", 8'h3F, {2'h0, i2s_pin_oe});
    chk("link_audio", 8'h2D, {2'h0, link_audio});
    $display("test audio done");
    for (int i = 0; i < 9; i++)
    begin
      @(posedge ref_clk);
      status_in <= st[i];
      cyc(6);
      rd(8'h5A, 8'hFF, sx[i]);
    end
    $display("test status done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h55, 8'h08 >> i);
      for (int j = 0; j < 4; j++)
      begin
        @(posedge ref_clk);
        case (j)
          0: pkt_info.audio_type <= ~pkt_info.audio_type;
          1: pkt_info.aif_sum <= ~pkt_info.aif_sum;
          2: pkt_info.avi_sum <= ~pkt_info.avi_sum;
          default: pkt_info.acr_cts <= ~pkt_info.acr_cts;
        endcase
        seen = 1'h0;
        repeat (3)
        begin
          cyc(1);
          seen = seen | fifo_reset;
        end
        chk("fifo_reset", {7'h00, i == j}, {7'h00, seen});
      end
    end
    $display("test fifo done");
    rd(8'h61, 8'h01, 8'h01);
    wr(8'h63, 8'h00);
    cyc(1);
    chk("irq", 8'h00, {7'h00, irq});
    wr(8'h63, 8'h01);
    cyc(1);
    chk("irq", 8'h01, {7'h00, irq});
    wr(8'h62, 8'h01);
    cyc(1);
    chk("irq", 8'h00, {7'h00, irq});
    rd(8'h61, 8'h01, 8'h00);
    rd(8'h62, 8'hFF, 8'h00);
    rd(8'h63, 8'h01, 8'h01);
    $display("test interrupt done");
    end_sim;
  end
endmodule
`default_nettype wire
